// >>> ptic_bus_if.sv
`timescale 1ns/1ps
interface ptic_bus_if;
    logic       ce_n;
    logic       wr_n;
    logic       rd_n;
    logic       reg_select_lo;
    logic       reg_select_hi;
    logic       reset_n;
    logic [7:0] host_d_o;
    logic       host_d_oe_n;
    logic [7:0] dev_d_o;
    logic       dev_d_oe_n;
    logic       int_n_o;
    logic       int_oe_n;
    logic [7:0] host_data_bus;
    logic       irq_n;

    // Wire levels; an undriven bus reads as pulled up
    assign host_data_bus = !host_d_oe_n ? host_d_o : (!dev_d_oe_n ? dev_d_o : 8'hff);
    assign irq_n         = !int_oe_n ? int_n_o : 1'b1;

    modport device (
        input  ce_n, wr_n, rd_n, reg_select_lo, reg_select_hi, reset_n, host_data_bus,
        output dev_d_o, dev_d_oe_n, int_n_o, int_oe_n
    );
    modport host (
        output ce_n, wr_n, rd_n, reg_select_lo, reg_select_hi, reset_n, host_d_o, host_d_oe_n,
        input  host_data_bus, irq_n
    );
endinterface : ptic_bus_if

// >>> ptic_bus_properties.sv
`timescale 1ns/1ps
module ptic_bus_properties (
    // Clock, reset and link levels
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ce_n,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic reset_n,
    input wire logic host_d_oe_n,
    input wire logic dev_d_oe_n,
    input wire logic int_oe_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    // Six cycles of slack cover the device's two-flop input sync
    a_read_drives: assert property ((!ce_n && !rd_n) [*6] |-> !dev_d_oe_n) else $error("no read data");
    a_idle_release: assert property (ce_n [*6] |-> dev_d_oe_n) else $error("bus kept");
    a_one_driver: assert property (host_d_oe_n || dev_d_oe_n) else $error("contention");
    a_strobe_select: assert property (!wr_n || !rd_n |-> !ce_n) else $error("unselected strobe");
    a_write_drives: assert property (!wr_n |-> !host_d_oe_n) else $error("write without data");
    a_strobe_width: assert property ($fell(wr_n) |-> !wr_n [*6]) else $error("short strobe");
    a_strobes_apart: assert property (wr_n || rd_n) else $error("both strobes");
    a_reset_irq: assert property (!reset_n [*6] |-> int_oe_n) else $error("irq in reset");
endmodule : ptic_bus_properties

// >>> ptic_device.sv
`timescale 1ns/1ps
module ptic_device
    import ptic_pkg::*;
#(
    parameter int STARTUP_CNT = STARTUP_CYCLES,
    parameter int TO_UNIT_CNT = TO_UNIT_CYCLES
)(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Parallel side
    ptic_bus_if.device bus,
    // I2C side, open drain
    input  wire logic scl_i,
    output      logic scl_o,
    output      logic scl_oe_n,
    input  wire logic sda_i,
    output      logic sda_o,
    output      logic sda_oe_n
);

    localparam int UPW  = $clog2(STARTUP_CNT + 1);
    localparam int PREW = $clog2(TO_UNIT_CNT + 1);

    if (STARTUP_CNT < 1 || TO_UNIT_CNT < 2)
        $error("ptic_device: start-up and timeout unit counts too small");

    typedef struct packed {
        logic [PIN_W-1:0] s1;
        logic [PIN_W-1:0] s2;
        logic             wr_prev;
        logic             scl_prev;
        logic             sda_prev;
        logic [7:0]       status;
        logic [7:0]       to_lim;
        logic [7:0]       data;
        logic [7:0]       adr;
        logic [7:0]       con;
        logic [UPW-1:0]   up_cnt;
        logic             ready;
        logic [6:0]       to_cnt;
        logic [PREW-1:0]  to_pre;
        logic             master;
        logic             sta_wait;
        logic [4:0]       osc_cnt;
        logic [3:0]       hold_cnt;
        logic [3:0]       bit_cnt;
        logic [7:0]       shift;
        logic             in_frame;
        logic             first;
        logic             addressed;
        logic             ack;
        logic             bus_err;
        logic [7:0]       dout;
        logic             doe_n;
        logic             int_oe_n;
        logic             scl_oe_n;
        logic             sda_oe_n;
    } ptic_dev_state_t;

    localparam ptic_dev_state_t DEV_RST = '{
        s1: '1, s2: '1, wr_prev: 1'b1, scl_prev: 1'b1, sda_prev: 1'b1,
        status: STATUS_RST, to_lim: TIMEOUT_RST, data: DATA_RST, adr: ADR_RST, con: CON_RST,
        doe_n: 1'b1, int_oe_n: 1'b1, scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0};

    ptic_dev_state_t r;
    ptic_dev_state_t n;

    logic [PIN_W-1:0] pins;
    logic             ce;
    logic             wr_rise;
    logic             rd;
    logic [1:0]       sel;
    logic [7:0]       din;
    logic             scl;
    logic             sda;
    logic             scl_rise;
    logic             scl_fall;
    logic             start_seen;
    logic             stop_seen;
    logic             osc_tick;

    ////////////////////////////////////////////////////////////////////////
    // Every pin passes two flops; logic reads only the second
    assign pins = {bus.reset_n, sda_i, scl_i, bus.host_data_bus,
                   bus.reg_select_hi, bus.reg_select_lo, bus.rd_n, bus.wr_n, bus.ce_n};

    assign ce         = ~r.s2[P_CE];
    assign wr_rise    = ce & r.s2[P_WR] & ~r.wr_prev;
    assign rd         = ce & ~r.s2[P_RD];
    assign sel        = r.s2[P_SEL +: 2];
    assign din        = r.s2[P_DIN +: 8];
    assign scl        = r.s2[P_SCL];
    assign sda        = r.s2[P_SDA];
    assign scl_rise   = scl & ~r.scl_prev;
    assign scl_fall   = ~scl & r.scl_prev;
    assign start_seen = scl & r.scl_prev & ~sda & r.sda_prev;
    assign stop_seen  = scl & r.scl_prev & sda & ~r.sda_prev;
    assign osc_tick   = (r.osc_cnt == 5'(OSC_TICK_CYCLES - 1));

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        n          = r;
        n.s1       = pins;
        n.s2       = r.s1;
        n.wr_prev  = r.s2[P_WR];
        n.scl_prev = scl;
        n.sda_prev = sda;
        n.osc_cnt  = osc_tick ? 5'h00 : r.osc_cnt + 5'h01;

        // Host writes land on the synced strobe's rising edge
        if (wr_rise)
        begin
            case (sel)
                SEL_STATUS:  n.to_lim = din;
                SEL_DATA:    n.data   = din;
                SEL_OWN_ADR: n.adr    = din;
                SEL_CONTROL: n.con    = din;
                default:     n.con    = r.con;
            endcase
        end

        // Oscillator start-up after enable; SCL and SDA ignored until then, host writes still land
        if (!r.con[CON_ENSER])
        begin
            n.up_cnt   = '0;
            n.ready    = 1'b0;
            n.status   = ST_IDLE;
            n.master   = 1'b0;
            n.sta_wait = 1'b0;
            n.in_frame = 1'b0;
            n.addressed = 1'b0;
            n.scl_oe_n = 1'b1;
            n.sda_oe_n = 1'b1;
        end
        else if (!r.ready)
        begin
            n.up_cnt = r.up_cnt + UPW'(1);
            n.ready  = (r.up_cnt == UPW'(STARTUP_CNT - 1));
        end
        else if (!r.bus_err)
        begin
            // Timeout supervision on every SCL edge
            if (scl_rise || scl_fall)
            begin
                n.to_cnt = r.to_lim[6:0];
                n.to_pre = '0;
            end
            else if (r.master && !scl && r.scl_oe_n && r.to_lim[TO_ENABLE])
            begin
                n.to_pre = r.to_pre + PREW'(1);
                if (r.to_pre == PREW'(TO_UNIT_CNT - 1))
                begin
                    n.to_pre = '0;
                    n.to_cnt = r.to_cnt - 7'h01;
                    if (r.to_cnt == 7'h00)
                    begin
                        n.bus_err   = 1'b1;
                        n.status    = ST_BUS_ERR;
                        n.con[CON_SI] = 1'b1;
                        n.master    = 1'b0;
                        n.sta_wait  = 1'b0;
                        n.scl_oe_n  = 1'b1;
                        n.sda_oe_n  = 1'b1;
                    end
                end
            end

            // Master START; the own address plays no part here
            if (!r.master && r.con[CON_STA] && !r.con[CON_SI] && !r.in_frame)
            begin
                n.master   = 1'b1;
                n.sta_wait = 1'b1;
                n.hold_cnt = '0;
                n.to_cnt   = r.to_lim[6:0];
                n.to_pre   = '0;
            end
            else if (r.sta_wait && scl && !n.bus_err)
            begin
                n.sda_oe_n = 1'b0;
                if (osc_tick)
                    n.hold_cnt = r.hold_cnt + 4'h1;
                if (r.hold_cnt == 4'(START_HOLD_TICKS))
                begin
                    // Park SCL low and hand the byte slot to software
                    n.scl_oe_n = 1'b0;
                    n.sta_wait = 1'b0;
                    n.status   = ST_START;
                    n.con[CON_SI] = 1'b1;
                end
            end
            else if (r.master && !r.sta_wait && r.con[CON_STO])
            begin
                // Release SCL; SDA is let go while SCL reads low, then pulled low once SCL reads high
                n.scl_oe_n = 1'b1;
                n.sda_oe_n = ~scl;
                if (scl && !r.sda_oe_n)
                begin
                    n.master       = 1'b0;
                    n.con[CON_STO] = 1'b0;
                    n.status       = ST_IDLE;
                end
            end

            // Slave receive path
            if (!r.master)
            begin
                if (start_seen)
                begin
                    n.in_frame  = 1'b1;
                    n.first     = 1'b1;
                    n.addressed = 1'b0;
                    n.bit_cnt   = '0;
                end
                else if (stop_seen)
                begin
                    n.in_frame  = 1'b0;
                    n.addressed = 1'b0;
                    n.sda_oe_n  = 1'b1;
                    if (r.addressed)
                    begin
                        n.status      = ST_STOP;
                        n.con[CON_SI] = 1'b1;
                    end
                end
                else if (r.in_frame && scl_rise && r.bit_cnt < 4'h8)
                begin
                    n.shift   = {r.shift[6:0], sda};
                    n.bit_cnt = r.bit_cnt + 4'h1;
                    if (r.bit_cnt == 4'h7)
                    begin
                        n.ack = 1'b0;
                        if (r.first)
                        begin
                            n.first = 1'b0;
                            if (n.shift[7:1] == r.adr[7:1] && !n.shift[0] && r.con[CON_AA])
                            begin
                                n.addressed   = 1'b1;
                                n.ack         = 1'b1;
                                n.data        = n.shift;
                                n.status      = ST_SLA_W;
                                n.con[CON_SI] = 1'b1;
                            end
                            else if (!r.con[CON_SI])
                                n.data = n.shift;
                        end
                        else if (r.addressed)
                        begin
                            n.ack         = r.con[CON_AA];
                            n.data        = n.shift;
                            n.status      = r.con[CON_AA] ? ST_DATA_ACK : ST_DATA_NACK;
                            n.con[CON_SI] = 1'b1;
                        end
                        else if (!r.con[CON_SI])
                            n.data = n.shift;
                    end
                end
                else if (r.in_frame && scl_fall && r.bit_cnt == 4'h8)
                begin
                    n.sda_oe_n = ~r.ack;
                    n.bit_cnt  = 4'h9;
                end
                else if (r.in_frame && scl_fall && r.bit_cnt == 4'h9)
                begin
                    n.sda_oe_n = 1'b1;
                    n.bit_cnt  = '0;
                end

                // Stretch SCL low while software owns the byte slot
                if (r.addressed && r.con[CON_SI] && !scl)
                    n.scl_oe_n = 1'b0;
                else if (!r.con[CON_SI])
                    n.scl_oe_n = 1'b1;
            end
        end

        // Read path and interrupt pin, both from flops
        n.doe_n = ~rd;
        case (sel)
            SEL_STATUS:  n.dout = r.status;
            SEL_DATA:    n.dout = r.data;
            SEL_OWN_ADR: n.dout = r.adr;
            SEL_CONTROL: n.dout = r.con;
            default:     n.dout = 8'h00;
        endcase
        n.int_oe_n = ~(n.con[CON_SI] & n.con[CON_ENSER]);

        // Reset pin clears everything except the synchronisers
        if (!r.s2[P_RST])
        begin
            n    = DEV_RST;
            n.s1 = pins;
            n.s2 = r.s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            r <= DEV_RST;
        else
            r <= n;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; open-drain pins only ever drive low
    assign bus.dev_d_o    = r.dout;
    assign bus.dev_d_oe_n = r.doe_n;
    assign bus.int_n_o    = 1'b0;
    assign bus.int_oe_n   = r.int_oe_n;
    assign scl_o          = 1'b0;
    assign scl_oe_n       = r.scl_oe_n;
    assign sda_o          = 1'b0;
    assign sda_oe_n       = r.sda_oe_n;

endmodule : ptic_device

// >>> ptic_host.sv
`timescale 1ns/1ps
module ptic_host
    import ptic_pkg::*;
#(
    parameter int PHASE_CNT = HOST_PHASE_CYCLES
)(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    // Software command port
    input  wire logic [1:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output      logic [15:0] rdata,
    // Parallel side
    ptic_bus_if.host bus
);

    if (PHASE_CNT < 6 || PHASE_CNT > 15)
        $error("ptic_host: phase length must cover the device synchroniser");

    typedef struct packed {
        ptic_host_phase_t phase;
        logic [3:0]       cnt;
        logic [8:0]       s1;
        logic [8:0]       s2;
        logic             is_read;
        logic [1:0]       sel;
        logic [7:0]       wdat;
        logic [7:0]       rdat;
        logic             rst_drive;
        logic             ce_n;
        logic             wr_n;
        logic             rd_n;
        logic             d_oe_n;
        logic [15:0]      rdata;
    } ptic_host_state_t;

    localparam ptic_host_state_t HOST_RST = '{
        phase: H_IDLE, s1: '1, s2: '1, ce_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, d_oe_n: 1'b1,
        default: '0};

    ptic_host_state_t r;
    ptic_host_state_t n;
    logic             last;

    assign last = (r.cnt == 4'(PHASE_CNT - 1));

    ////////////////////////////////////////////////////////////////////////
    // Phase sequencer and command registers
    always_comb
    begin
        n       = r;
        n.s1    = {bus.irq_n, bus.host_data_bus};
        n.s2    = r.s1;
        n.cnt   = last ? 4'h0 : r.cnt + 4'h1;
        n.rdata = 16'h0000;

        case (r.phase)
            H_IDLE:
            begin
                n.cnt = 4'h0;
                if (wr && addr == HREG_CMD)
                begin
                    n.phase   = H_SETUP;
                    n.sel     = wdata[CMD_SEL +: 2];
                    n.is_read = wdata[CMD_READ];
                    n.wdat    = wdata[7:0];
                    n.ce_n    = 1'b0;
                    n.d_oe_n  = wdata[CMD_READ];
                end
            end
            H_SETUP:
                if (last)
                begin
                    n.phase = H_STROBE;
                    n.wr_n  = r.is_read;
                    n.rd_n  = ~r.is_read;
                end
            H_STROBE:
                if (last)
                begin
                    n.phase = H_HOLD;
                    n.wr_n  = 1'b1;
                    n.rd_n  = 1'b1;
                    if (r.is_read)
                        n.rdat = r.s2[7:0];
                end
            H_HOLD:
                if (last)
                begin
                    n.phase  = H_IDLE;
                    n.ce_n   = 1'b1;
                    n.d_oe_n = 1'b1;
                end
            default:
                n.phase = H_IDLE;
        endcase

        // Software drives the reset pin after a bus error
        if (wr && addr == HREG_CTRL)
            n.rst_drive = wdata[0];

        if (rd)
        begin
            case (addr)
                HREG_STAT:  n.rdata = {13'h0000, r.rst_drive, ~r.s2[8], r.phase != H_IDLE};
                HREG_RDATA: n.rdata = {8'h00, r.rdat};
                HREG_CTRL:  n.rdata = {15'h0000, r.rst_drive};
                default:    n.rdata = 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            r <= HOST_RST;
        else
            r <= n;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata             = r.rdata;
    assign bus.ce_n          = r.ce_n;
    assign bus.wr_n          = r.wr_n;
    assign bus.rd_n          = r.rd_n;
    assign bus.reg_select_lo = r.sel[0];
    assign bus.reg_select_hi = r.sel[1];
    assign bus.host_d_o      = r.wdat;
    assign bus.host_d_oe_n   = r.d_oe_n;
    assign bus.reset_n       = ~r.rst_drive;

endmodule : ptic_host

// >>> ptic_pkg.sv
// Operation
// - I2C timing from internal nominal 9 MHz tick; here only the START hold uses it, the timeout unit counts ref_clk cycles
// - Wait 500 us start-up after enable set
// - Select 00 status/timeout, 01 data, 10 address, 11 control
// - Host avoids writes while bus busy and engaged
// - Reload timeout counter on every SCL transition
// - Timeout register bit 7 enables supervision
// - Stuck SCL before START: status 90, interrupt, release
// - Host reads status, then applies external reset
// - Master counts SCL low; error at period
// - Own address untouched by engine, ignored as master
// - Own address in bits 7..1, MSB first
// - Host writes own address bit 0 as zero
// - Master address byte: MSB bit 7, direction bit 0
// - Data register accessed only while flag set
// - Data register holds last transferred byte at interrupt
// - Received address byte captured as data
// - Unaddressed capture continues; host reloads data afterwards
// - Byte-wise transfer, master or slave, interrupt or poll; master side here only sends START, STO frees SCL and pulls SDA low, slave only receives
// - Write loads selected register at strobe rising edge
// - Read drives data bus; otherwise bus released
// - Low reset pin clears registers and engine
// - Interrupt active low open drain; control write clears
package ptic_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register select codes on the parallel bus
    localparam logic [1:0] SEL_STATUS  = 2'h0;   // Read status, write timeout
    localparam logic [1:0] SEL_DATA    = 2'h1;
    localparam logic [1:0] SEL_OWN_ADR = 2'h2;
    localparam logic [1:0] SEL_CONTROL = 2'h3;

    // Values after reset
    localparam logic [7:0] STATUS_RST  = 8'hf8;
    localparam logic [7:0] TIMEOUT_RST = 8'hff;
    localparam logic [7:0] DATA_RST    = 8'h00;
    localparam logic [7:0] ADR_RST     = 8'h00;
    localparam logic [7:0] CON_RST     = 8'h00;

    // Control and timeout field positions
    localparam int CON_AA    = 7;
    localparam int CON_ENSER = 6;                 // serial_enable_bit
    localparam int CON_STA   = 5;
    localparam int CON_STO   = 4;
    localparam int CON_SI    = 3;
    localparam int TO_ENABLE = 7;                 // timeout_enable_bit

    // Status codes
    localparam logic [7:0] ST_IDLE      = 8'hf8;
    localparam logic [7:0] ST_BUS_ERR   = 8'h90;
    localparam logic [7:0] ST_START     = 8'h08;
    localparam logic [7:0] ST_SLA_W     = 8'h60;
    localparam logic [7:0] ST_DATA_ACK  = 8'h80;
    localparam logic [7:0] ST_DATA_NACK = 8'h88;
    localparam logic [7:0] ST_STOP      = 8'ha0;

    // Pin positions in the device's synchroniser vector
    localparam int P_CE  = 0;
    localparam int P_WR  = 1;
    localparam int P_RD  = 2;
    localparam int P_SEL = 3;                     // Two bits, lo first
    localparam int P_DIN = 5;                     // Eight bits
    localparam int P_SCL = 13;
    localparam int P_SDA = 14;
    localparam int P_RST = 15;
    localparam int PIN_W = 16;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS   = 5;
    localparam int CLK_HZ          = 200000000;
    localparam int OSC_HZ          = 9000000;
    localparam int OSC_TICK_CYCLES = CLK_HZ / OSC_HZ;
    localparam int START_HOLD_TICKS = 6;          // About 0.67 us of START hold
    localparam int STARTUP_US      = 500;
    localparam int STARTUP_CYCLES  = STARTUP_US * 1000 / CLK_PERIOD_NS;
    localparam int TO_UNIT_TENTH_US = 1137;       // 113.7 us
    localparam int TO_UNIT_CYCLES  = TO_UNIT_TENTH_US * 100 / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Host controller command port
    localparam logic [1:0] HREG_CMD   = 2'h0;
    localparam logic [1:0] HREG_STAT  = 2'h1;
    localparam logic [1:0] HREG_RDATA = 2'h2;
    localparam logic [1:0] HREG_CTRL  = 2'h3;
    localparam int CMD_SEL  = 8;                  // Two bits
    localparam int CMD_READ = 10;
    localparam int HOST_PHASE_CYCLES = 8;

    typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD} ptic_host_phase_t;

endpackage : ptic_pkg

// >>> test_parallel_to_i2c_register_core.sv
`timescale 1ns/1ps
module test_parallel_to_i2c_register_core;
    import ptic_pkg::*;
    logic        ref_clk = 1'h0, sys_rst = 1'h1, wr = 1'h0, rd = 1'h0, scl_tb = 1'h1, sda_tb = 1'h1, scl_oe_n, sda_oe_n;
    logic [1:0]  addr = 2'h0;
    logic [7:0]  v, a;
    logic [15:0] wdata = 16'h0, rdata;
    int          bad_count = 0, num_checks = 0;
    // Pulled-up SCL and SDA; bench and device both may pull them low
    wire         scl = scl_tb & scl_oe_n;
    wire         sda = sda_tb & sda_oe_n;
    ptic_bus_if bus ();
    ptic_host i_ptic_host (.ref_clk, .sys_rst, .addr, .wdata, .wr, .rd, .rdata, .bus(bus.host));
    ptic_device #(.STARTUP_CNT(20), .TO_UNIT_CNT(4)) i_ptic_device (.ref_clk, .sys_rst, .bus(bus.device),
        .scl_i(scl), .scl_o(), .scl_oe_n, .sda_i(sda), .sda_o(), .sda_oe_n);
    ptic_bus_properties i_ptic_bus_properties (.ref_clk, .sys_rst, .ce_n(bus.ce_n), .wr_n(bus.wr_n),
        .rd_n(bus.rd_n), .reset_n(bus.reset_n), .host_d_oe_n(bus.host_d_oe_n), .dev_d_oe_n(bus.dev_d_oe_n),
        .int_oe_n(bus.int_oe_n));
    initial forever #2.5 ref_clk = ~ref_clk;
    // Hang guard
    initial
    begin
        repeat (30000) @(posedge ref_clk);
        bad_count++;
        finish_test();
    end
    task finish_test();
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e)
            $display("ERROR %s exp %h got %h", n, e, s);
        bad_count += int'(s !== e);
    endtask : chk
    // Register values after reset, by select code
    function automatic logic [7:0] exp_reset(input logic [1:0] s);
        return (s == SEL_STATUS) ? STATUS_RST : (s == SEL_DATA) ? DATA_RST : (s == SEL_OWN_ADR) ? ADR_RST : CON_RST;
    endfunction : exp_reset
    // Host status word with an idle sequencer and the reset pin released
    function automatic logic [7:0] exp_stat(input logic irq);
        return {6'h00, irq, 1'h0};
    endfunction : exp_stat
    // One strobe; read data caught in the next cycle
    task sw(input logic [1:0] ad, input logic [15:0] d, input logic w);
        @(posedge ref_clk);
        {addr, wdata, wr, rd} <= {ad, d, w, !w};
        @(posedge ref_clk);
        {wr, rd} <= 2'h0;
        @(negedge ref_clk);
        v = rdata[7:0];
    endtask : sw
    // Device access; a host transfer takes 24 cycles
    task dev(input logic [1:0] s, input logic [7:0] d, input logic r);
        sw(HREG_CMD, {5'h0, r, s, d}, 1'h1);
        repeat (30) @(posedge ref_clk);
        sw(HREG_RDATA, 16'h0, 1'h0);
    endtask : dev
    // Bench master: START, eight bits MSB first on a 125 ns SCL, then the ack slot
    task i2c_addr(input logic [7:0] b);
        sda_tb <= 1'h0;
        repeat (12) @(posedge ref_clk);
        for (int i = 7; i >= 0; i--)
        begin
            scl_tb <= 1'h0;
            repeat (6) @(posedge ref_clk);
            sda_tb <= b[i];
            repeat (7) @(posedge ref_clk);
            scl_tb <= 1'h1;
            repeat (12) @(posedge ref_clk);
        end
        scl_tb <= 1'h0;
        repeat (6) @(posedge ref_clk);
        sda_tb <= 1'h1;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask : i2c_addr
    initial
    begin
        void'($urandom(32'h5fe407e2));
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'h0;
        // Power-up values
        for (int s = 0; s < 4; s++)
        begin
            dev(s[1:0], 8'h0, 1'h1);
            chk("reset", v, exp_reset(s[1:0]));
        end
        // Random own addresses
        repeat (4)
        begin
            a = 8'($urandom) & 8'hfe;
            dev(SEL_OWN_ADR, a, 1'h0);
            dev(SEL_OWN_ADR, 8'h0, 1'h1);
            chk("own_adr", v, a);
        end
        // START wanted while SCL is held low, supervision off
        @(posedge ref_clk);
        scl_tb <= 1'h0;
        dev(SEL_STATUS, 8'h01, 1'h0);
        dev(SEL_CONTROL, 8'h40, 1'h0);
        repeat (40) @(posedge ref_clk);
        dev(SEL_CONTROL, 8'h60, 1'h0);
        repeat (300) @(posedge ref_clk);
        dev(SEL_STATUS, 8'h0, 1'h1);
        chk("no_error", v, ST_IDLE);
        // Limit 1: two units of four cycles
        dev(SEL_STATUS, 8'h81, 1'h0);
        repeat (20) @(posedge ref_clk);
        dev(SEL_STATUS, 8'h0, 1'h1);
        chk("bus_error", v, ST_BUS_ERR);
        sw(HREG_STAT, 16'h0, 1'h0);
        chk("error_irq", v, exp_stat(1'h1));
        chk("lines_free", {6'h00, scl_oe_n, sda_oe_n}, 8'h03);
        // A control write drops the interrupt request
        dev(SEL_CONTROL, 8'h40, 1'h0);
        sw(HREG_STAT, 16'h0, 1'h0);
        chk("irq_cleared", v, exp_stat(1'h0));
        // Reset pin brings the engine back
        sw(HREG_CTRL, 16'h1, 1'h1);
        repeat (10) @(posedge ref_clk);
        sw(HREG_CTRL, 16'h0, 1'h1);
        @(posedge ref_clk);
        scl_tb <= 1'h1;
        repeat (10) @(posedge ref_clk);
        dev(SEL_STATUS, 8'h0, 1'h1);
        chk("recovered", v, STATUS_RST);
        // Slave addressed by its own address; only reads while it holds the bus
        a = 8'($urandom) & 8'hfe;
        dev(SEL_OWN_ADR, a, 1'h0);
        dev(SEL_CONTROL, 8'hc0, 1'h0);
        repeat (30) @(posedge ref_clk);
        i2c_addr(a);
        chk("ack", {7'h00, sda}, 8'h00);
        @(posedge ref_clk);
        scl_tb <= 1'h1;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("stretch", {7'h00, scl}, 8'h00);
        dev(SEL_STATUS, 8'h0, 1'h1);
        chk("addressed", v, ST_SLA_W);
        sw(HREG_STAT, 16'h0, 1'h0);
        chk("slave_irq", v, exp_stat(1'h1));
        dev(SEL_DATA, 8'h0, 1'h1);
        chk("adr_as_data", v, a);
        dev(SEL_OWN_ADR, 8'h0, 1'h1);
        chk("adr_kept", v, a);
        finish_test();
    end
endmodule : test_parallel_to_i2c_register_core
